// ==== pkg/brc_regs.vh ====
// constants for the bidirectional reset control block
`ifndef BRC_REGS_VH
`define BRC_REGS_VH
// ==================================================
// register offsets
`define BRC_OFS_CONFIG   8'h00
`define BRC_OFS_STATUS   8'h04
`define BRC_OFS_INTSTAT  8'h08
`define BRC_OFS_INTMASK  8'h0C
`define BRC_OFS_BOOTCFG  8'h10
// ==================================================
// config fields
`define BRC_CFG_ENABLE   0
`define BRC_CFG_END_OF_INIT_INSTRUCTION    1
// status fields
`define BRC_ST_ACTIVE    0
`define BRC_ST_SEQ       1
`define BRC_ST_LONGHW    2
`define BRC_ST_SHORTHW   3
`define BRC_ST_SWRST     4
`define BRC_ST_LOADER    5
// interrupt events
`define BRC_EV_RESETDONE 0
`define BRC_EV_STRETCHED 1
`define BRC_EV_LOCKWRITE 2
`define BRC_EV_WIDTH     3
// ==================================================
// reset values and timing
`define BRC_CONFIG_RESET 2'h0
`define BRC_MASK_RESET   3'h0
`define BRC_SEQ_NS       5120
`define BRC_CLK_NS       5
`define BRC_SEQ_CYCLES   ((`BRC_SEQ_NS + `BRC_CLK_NS - 1) / `BRC_CLK_NS)
`define BRC_LONG_CYCLES  4
`define BRC_BOOT_SEL_BIT 4
`endif

// ==== rtl/brc_sync.v ====
// two-flop synchroniser for pin inputs
module brc_sync #(
  parameter WIDTH = 1
) (
  input  wire             i_clock,
  input  wire             i_resetn,
  input  wire [WIDTH-1:0] i_async,
  input  wire [WIDTH-1:0] i_reset_value,
  output reg  [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage1;

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= {WIDTH{1'b1}};
      o_sync <= {WIDTH{1'b1}};
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

  // i_reset_value kept for port symmetry; constant preset used
  wire unused_ok = &{1'b0, i_reset_value};
endmodule // brc_sync

// ==== rtl/brc_reset_ctrl.v ====
// bidirectional reset control with wishbone register access
//
// Implementation choices: the register addresses and the Wishbone slave port.
`include "brc_regs.vh"
module brc_reset_ctrl #(
  parameter SEQ_CYCLES  = `BRC_SEQ_CYCLES,
  parameter LONG_CYCLES = `BRC_LONG_CYCLES,
  parameter BOOT_WIDTH  = 16
) (
  input  wire                  i_clock,
  input  wire                  i_resetn,
  input  wire                  i_wb_cyc,
  input  wire                  i_wb_stb,
  input  wire                  i_wb_we,
  input  wire [7:0]            i_wb_adr,
  input  wire [3:0]            i_wb_sel,
  input  wire [31:0]           i_wb_dat,
  output reg  [31:0]           o_wb_dat,
  output reg                   o_wb_ack,
  input  wire                  i_end_of_init_instruction,
  input  wire                  i_software_reset,
  input  wire                  i_watchdog_reset,
  input  wire                  i_reset_input_pin,
  output wire                  o_reset_input_pin,
  output wire                  o_reset_input_pin_oe,
  input  wire [BOOT_WIDTH-1:0] i_boot_config_port,
  output reg  [BOOT_WIDTH-1:0] o_boot_config,
  output reg                   o_bootstrap_loader,
  output reg                   o_system_reset,
  output wire                  o_interrupt
);
  // ==================================================
  // state machine codes
  localparam ST_RUN  = 3'b001;
  localparam ST_SEQ  = 3'b010;
  localparam ST_HOLD = 3'b100;

  reg  [2:0]            state;
  reg  [2:0]            next_state;
  reg  [15:0]           seq_count;
  reg  [15:0]           low_count;
  reg                   bidir_reset_enable_bit;
  reg                   end_of_init_instruction_done;
  reg                   active_latched;
  reg                   flag_longhw;
  reg                   flag_shorthw;
  reg                   flag_swrst;
  reg                   stretched;
  reg                   power_on_seq;
  reg  [1:0]            oe_hist;
  reg  [`BRC_EV_WIDTH-1:0] int_status;
  reg  [`BRC_EV_WIDTH-1:0] int_mask;
  reg  [`BRC_EV_WIDTH-1:0] events;
  wire                  pin_sync;
  wire [BOOT_WIDTH-1:0] boot_sync;

  // ==================================================
  // pin synchronisers
  brc_sync #(.WIDTH(1)) u_pin_sync (
    .i_clock       (i_clock),
    .i_resetn      (i_resetn),
    .i_async       (i_reset_input_pin),
    .i_reset_value (1'b1),
    .o_sync        (pin_sync)
  );

  brc_sync #(.WIDTH(BOOT_WIDTH)) u_boot_sync (
    .i_clock       (i_clock),
    .i_resetn      (i_resetn),
    .i_async       (i_boot_config_port),
    .i_reset_value ({BOOT_WIDTH{1'b1}}),
    .o_sync        (boot_sync)
  );

  function wire_hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      wire_hit = (adr == ofs);
    end
  endfunction

  wire bus_req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_write = bus_req & i_wb_we & i_wb_sel[0];
  // own drive still echoes through the synchroniser for two cycles after release
  wire pin_low   = ~pin_sync & ~o_reset_input_pin_oe & ~|oe_hist;
  wire int_req   = i_software_reset | i_watchdog_reset;
  wire seq_last  = (seq_count == 16'h0001);

  // ==================================================
  // reset sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (int_req | pin_low)
          next_state = ST_SEQ;
      end
      ST_SEQ: begin
        if (seq_last)
          next_state = pin_low ? ST_HOLD : ST_RUN;
      end
      ST_HOLD: begin
        if (pin_sync)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state          <= ST_SEQ;
      seq_count      <= SEQ_CYCLES[15:0];
      low_count      <= 16'h0000;
      active_latched <= 1'b0;
      o_system_reset <= 1'b1;
      flag_longhw    <= 1'b1;
      flag_shorthw   <= 1'b0;
      flag_swrst     <= 1'b0;
      stretched      <= 1'b0;
      power_on_seq   <= 1'b1;
    end else begin
      state <= next_state;
      if (state == ST_RUN && next_state == ST_SEQ) begin
        seq_count      <= SEQ_CYCLES[15:0];
        low_count      <= 16'h0000;
        active_latched <= bidir_reset_enable_bit;
        stretched      <= 1'b0;
      end else if (state == ST_SEQ) begin
        seq_count <= seq_count - 16'h0001;
        if (pin_low && low_count != 16'hFFFF)
          low_count <= low_count + 16'h0001;
        if (!pin_low && active_latched)
          stretched <= 1'b1;
      end
      o_system_reset <= (next_state != ST_RUN);
      if (state == ST_SEQ && seq_last) begin
        power_on_seq <= 1'b0;
        if (active_latched) begin
          flag_longhw  <= 1'b1;
          flag_shorthw <= 1'b0;
          flag_swrst   <= 1'b0;
        end else begin
          flag_longhw  <= (low_count >= LONG_CYCLES[15:0]);
          flag_shorthw <= (low_count != 16'h0000) && (low_count < LONG_CYCLES[15:0]);
          flag_swrst   <= (low_count == 16'h0000);
        end
      end
    end
  end

  // pull pin low during the sequence if enabled at its start (active_latched); external side open-drain
  assign o_reset_input_pin    = 1'b0;
  assign o_reset_input_pin_oe = (state == ST_SEQ) & active_latched;

  // history of own pin drive, masks the synchroniser echo
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn)
      oe_hist <= 2'b00;
    else
      oe_hist <= {oe_hist[0], o_reset_input_pin_oe};
  end

  // ==================================================
  // boot configuration latch
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_boot_config      <= {BOOT_WIDTH{1'b1}};
      o_bootstrap_loader <= 1'b0;
    end else if (state == ST_SEQ && seq_last &&
                 (active_latched || power_on_seq || low_count >= LONG_CYCLES[15:0])) begin
      o_boot_config      <= boot_sync;
      o_bootstrap_loader <= ~boot_sync[`BRC_BOOT_SEL_BIT];
    end
  end

  // ==================================================
  // system configuration register
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bidir_reset_enable_bit <= 1'b0;
      end_of_init_instruction_done             <= 1'b0;
    end else if (o_system_reset) begin
      bidir_reset_enable_bit <= 1'b0;
      end_of_init_instruction_done             <= 1'b0;
    end else begin
      if (i_end_of_init_instruction)
        end_of_init_instruction_done <= 1'b1;
      if (bus_write && wire_hit(i_wb_adr, `BRC_OFS_CONFIG) && !end_of_init_instruction_done)
        bidir_reset_enable_bit <= i_wb_dat[`BRC_CFG_ENABLE];
    end
  end

  // ==================================================
  // interrupts
  always @* begin
    events = {`BRC_EV_WIDTH{1'b0}};
    events[`BRC_EV_RESETDONE] = (state == ST_SEQ) & seq_last;
    events[`BRC_EV_STRETCHED] = (state == ST_SEQ) & seq_last & stretched;
    events[`BRC_EV_LOCKWRITE] = bus_write & wire_hit(i_wb_adr, `BRC_OFS_CONFIG) & end_of_init_instruction_done;
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      int_status <= {`BRC_EV_WIDTH{1'b0}};
      int_mask   <= `BRC_MASK_RESET;
    end else begin
      if (bus_write && wire_hit(i_wb_adr, `BRC_OFS_INTSTAT))
        int_status <= (int_status & ~i_wb_dat[`BRC_EV_WIDTH-1:0]) | events;
      else
        int_status <= int_status | events;
      if (bus_write && wire_hit(i_wb_adr, `BRC_OFS_INTMASK))
        int_mask <= i_wb_dat[`BRC_EV_WIDTH-1:0];
    end
  end

  assign o_interrupt = |(int_status & int_mask);

  // ==================================================
  // wishbone slave, ack one cycle after request
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= 32'h00000000;
      if (bus_req && !i_wb_we) begin
        case (i_wb_adr)
          `BRC_OFS_CONFIG:  o_wb_dat <= {30'h0, end_of_init_instruction_done, bidir_reset_enable_bit};
          `BRC_OFS_STATUS:  o_wb_dat <= {26'h0, o_bootstrap_loader, flag_swrst, flag_shorthw,
                                         flag_longhw, (state != ST_RUN), active_latched};
          `BRC_OFS_INTSTAT: o_wb_dat <= {29'h0, int_status};
          `BRC_OFS_INTMASK: o_wb_dat <= {29'h0, int_mask};
          `BRC_OFS_BOOTCFG: o_wb_dat <= {{(32-BOOT_WIDTH){1'b0}}, o_boot_config};
          default:          o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // brc_reset_ctrl

// ==== verification/brc_properties.sv ====
// concurrent checks on the reset control block ports
module brc_properties #(
  parameter SEQ_CYCLES = 1024,
  parameter BOOT_WIDTH = 16
) (
  input wire                  i_clock,
  input wire                  i_resetn,
  input wire                  i_wb_cyc,
  input wire                  i_wb_stb,
  input wire                  i_wb_we,
  input wire [7:0]            i_wb_adr,
  input wire                  i_reset_input_pin,
  input wire [31:0]           o_wb_dat,
  input wire                  o_wb_ack,
  input wire                  o_reset_input_pin,
  input wire                  o_reset_input_pin_oe,
  input wire [BOOT_WIDTH-1:0] o_boot_config,
  input wire                  o_bootstrap_loader,
  input wire                  o_system_reset
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned hi_cnt;
  // ==================================================
  // length of the current reset sequence
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) hi_cnt <= 0;
    else hi_cnt <= o_system_reset ? hi_cnt + 1 : 0;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_cfg_read;
    o_wb_ack && !i_wb_we && i_wb_adr == 8'h00;
  endsequence
  ack_timely_a: assert property (s_req |=> o_wb_ack)
    else $error("ack missing after request");
  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  seq_length_a: assert property ($fell(o_system_reset) |-> hi_cnt >= SEQ_CYCLES)
    else $error("reset sequence too short");
  pin_entry_a: assert property ($fell(i_reset_input_pin) |-> ##[1:5] o_system_reset)
    else $error("pin reset did not start sequence");
  drive_seq_a: assert property (o_reset_input_pin_oe |-> o_system_reset)
    else $error("pin driven outside sequence");
  drive_low_a: assert property (o_reset_input_pin_oe |-> !o_reset_input_pin)
    else $error("pin driven high");
  loader_sel_a: assert property (o_bootstrap_loader == !o_boot_config[4])
    else $error("loader flag disagrees with select bit");
  enable_clr_a: assert property ((s_cfg_read ##0 $past(o_system_reset, 2)) |-> !o_wb_dat[0])
    else $error("enable bit set during reset");
  no_echo_a: assert property ($fell(o_reset_input_pin_oe) |-> !o_system_reset [*3])
    else $error("own pin drive restarted reset");
endmodule // brc_properties

bind brc_reset_ctrl brc_properties #(
  .SEQ_CYCLES (SEQ_CYCLES),
  .BOOT_WIDTH (BOOT_WIDTH)
) i_brc_properties (
  .i_clock              (i_clock),
  .i_resetn             (i_resetn),
  .i_wb_cyc             (i_wb_cyc),
  .i_wb_stb             (i_wb_stb),
  .i_wb_we              (i_wb_we),
  .i_wb_adr             (i_wb_adr),
  .i_reset_input_pin    (i_reset_input_pin),
  .o_wb_dat             (o_wb_dat),
  .o_wb_ack             (o_wb_ack),
  .o_reset_input_pin    (o_reset_input_pin),
  .o_reset_input_pin_oe (o_reset_input_pin_oe),
  .o_boot_config        (o_boot_config),
  .o_bootstrap_loader   (o_bootstrap_loader),
  .o_system_reset       (o_system_reset)
);

// ==== verification/brc_supervisor.sv ====
// open-drain external reset source sharing the reset line
module brc_supervisor (
  input  wire i_clock,
  input  wire i_device_oe,
  output wire o_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pull = 1'b0;
  // only ever pulls low; pull-up gives the high level
  assign o_line = !(pull || i_device_oe);
  task automatic press(input int n);
    @(posedge i_clock);
    pull <= 1'b1;
    repeat (n) @(posedge i_clock);
    pull <= 1'b0;
  endtask
endmodule // brc_supervisor

// ==== verification/testbench.sv ====
// self-checking bench for the bidirectional reset control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        end_of_init_instruction = 1'b0, swr = 1'b0, wdt = 1'b0, ack, line, oe, opin, ldr, srst, irq;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [15:0] port = 16'hFFEF, bcfg;
  int          n_fail = 0, checked = 0;
  always #2.5 clk = ~clk;
  brc_reset_ctrl #(.SEQ_CYCLES(16)) i_brc_reset_ctrl (
    .i_clock(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_end_of_init_instruction(end_of_init_instruction), .i_software_reset(swr), .i_watchdog_reset(wdt),
    .i_reset_input_pin(line), .o_reset_input_pin(opin), .o_reset_input_pin_oe(oe),
    .i_boot_config_port(port), .o_boot_config(bcfg), .o_bootstrap_loader(ldr),
    .o_system_reset(srst), .o_interrupt(irq));
  brc_supervisor i_brc_supervisor (.i_clock(clk), .i_device_oe(oe), .o_line(line));
  // ==================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (srst !== 1'b0 && n++ < 300) @(posedge clk);
  endtask
  task automatic wait_seq;
    int n;
    n = 0;
    while (srst !== 1'b1 && n++ < 20) @(posedge clk);
    chk(srst, 32'h1);
    wait_run();
  endtask
  task automatic arm;
    wait_run();
    wb(1'b0, 8'h00, 32'h0);
    chk(q[0], 32'h0);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk(q[0], 32'h1);
  endtask
  // ==================================================
  // scenarios
  task automatic t_src(input logic wd);
    arm();
    @(posedge clk);
    if (wd) wdt <= 1'b1;
    else swr <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    swr <= 1'b0;
    repeat (4) @(posedge clk);
    chk(oe, 32'h1);
    chk(line, 32'h0);
    chk(opin, 32'h0);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk(q[0], 32'h0);
    wait_run();
    wb(1'b0, 8'h04, 32'h0);
    chk(q[4:2], 32'h1);
    chk(bcfg, 32'hFFEF);
    chk(ldr, 32'h1);
  endtask
  task automatic t_pin;
    int n;
    n = 0;
    arm();
    wb(1'b1, 8'h08, 32'h7);
    i_brc_supervisor.press(2);
    while (srst !== 1'b1 && n++ < 10) @(posedge clk);
    n = 0;
    while (srst === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 16, 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    chk(q[1:0], 32'h3);
    wb(1'b0, 8'h04, 32'h0);
    chk(q[4:2], 32'h1);
  endtask
  task automatic t_plain;
    wait_run();
    port <= 16'hFFFF;
    i_brc_supervisor.press(30);
    chk(srst, 32'h1);
    chk(oe, 32'h0);
    wait_run();
    wb(1'b0, 8'h04, 32'h0);
    chk(q[5:0], 32'h04);
    chk(bcfg, 32'hFFFF);
    chk(ldr, 32'h0);
    port <= 16'hFFEF;
    i_brc_supervisor.press(2);
    wait_seq();
    wb(1'b0, 8'h04, 32'h0);
    chk(q[4:2], 32'h2);
    chk(bcfg, 32'hFFFF);
  endtask
  task automatic t_hwreset;
    arm();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(srst, 32'h1);
    rstn <= 1'b1;
    wait_run();
    wb(1'b0, 8'h00, 32'h0);
    chk(q[0], 32'h0);
    chk(bcfg, 32'hFFEF);
    chk(ldr, 32'h1);
  endtask
  task automatic t_lock;
    arm();
    wb(1'b1, 8'h0C, 32'h7);
    @(posedge clk);
    end_of_init_instruction <= 1'b1;
    @(posedge clk);
    end_of_init_instruction <= 1'b0;
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk(q[0], 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    chk(q[2], 32'h1);
    chk(irq, 32'h1);
    wb(1'b1, 8'h0C, 32'h0);
    chk(irq, 32'h0);
    wb(1'b1, 8'h0C, 32'h7);
    wb(1'b1, 8'h08, 32'h7);
    chk(irq, 32'h0);
    wb(1'b0, 8'hF0, 32'h0);
    chk(q, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_src(1'b0);
    t_src(1'b1);
    t_pin();
    t_plain();
    t_hwreset();
    t_lock();
    end_sim();
  end
  initial begin
    #50us;
    n_fail++;
    end_sim();
  end
endmodule // testbench
